// *** src/fpd_partition_decode.sv ***
// partition decode and dual work read routing for the flash array
//
// Behaviour
// - main blocks 32K words, parameter blocks 4K
// - small array: eight parameter, 63 main blocks
// - large array: eight parameter, 127 main blocks
// - array split into four address-selected planes
// - parameter blocks only in first or last plane
// - read other partition during program or erase
// - partitions are one to four whole planes
// - code 111 makes every plane a partition
// - plane follows word address range per density
// - partition derived from address, no select input
// - reset merges planes 0-2 or 1-3
// - read of partition busy with a local op returns status
// - no dual reads during chip erase, OTP
`timescale 1ns/1ns
`include "fpd_regs.svh"

module fpd_partition_decode #(
  parameter bit DENSITY_64 = 1'b1,
  parameter bit TOP_PARAM  = 1'b1
) (
  input  logic               clock_i,
  input  logic               srst_i,
  input  logic               cfg_wr_i,
  input  logic [2:0]         cfg_code_i,
  input  logic               req_valid_i,
  input  logic               req_read_i,
  input  fpd_pkg::fpd_addr_t req_addr_i,
  input  logic               op_busy_i,
  input  logic               op_global_i,
  input  fpd_pkg::fpd_addr_t op_addr_i,
  output logic               rsp_valid_o,
  output fpd_pkg::fpd_rsp_t  rsp_o,
  output logic [2:0]         cfg_code_o,
  output logic [3:0]         part_busy_o
);
  import fpd_pkg::*;

  localparam int PL = DENSITY_64 ? `FPD_PLANE_LSB_64M : `FPD_PLANE_LSB_32M;
  localparam logic [2:0] PCFG_RST = TOP_PARAM ? `FPD_PCFG_RST_TOP : `FPD_PCFG_RST_BOT;

  // the address type must hold the 2-bit plane index
  if (PL + 2 > $bits(fpd_addr_t)) begin : g_aw_bad
    $error("fpd_partition_decode: plane bits outside address");
  end

  fpd_loc_t   req_loc;
  fpd_loc_t   op_loc;
  logic [1:0] req_part;
  logic [1:0] op_part;
  fpd_src_t   nxt_src;
  logic [3:0] nxt_part_busy;
  logic [2:0] cfg_code_ff;
  logic       rsp_valid_ff;
  fpd_rsp_t   rsp_ff;
  logic [3:0] part_busy_ff;

  // incoming access location
  fpd_addr_decode #(
    .DENSITY_64 (DENSITY_64),
    .TOP_PARAM  (TOP_PARAM)
  ) u_req_dec (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .addr_i  (req_addr_i),
    .loc_o   (req_loc)
  );

  // location of the program or erase in flight
  fpd_addr_decode #(
    .DENSITY_64 (DENSITY_64),
    .TOP_PARAM  (TOP_PARAM)
  ) u_op_dec (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .addr_i  (op_addr_i),
    .loc_o   (op_loc)
  );

  // partition config; frozen while an operation runs, since moving a
  // boundary under a busy plane would let reads hit the plane in work
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_code_ff <= PCFG_RST;
    end else if (cfg_wr_i && !op_busy_i) begin
      cfg_code_ff <= cfg_code_i;
    end
  end

  // partitions come from plane bits and boundary code only
  assign req_part = fpd_part_of(cfg_code_ff, req_loc.plane);
  assign op_part  = fpd_part_of(cfg_code_ff, op_loc.plane);

  // read routing: array, the partition status, or refused
  always_comb begin
    nxt_src = FPD_SRC_ARRAY;
    if (req_read_i && op_busy_i) begin
      if (op_global_i) begin
        nxt_src = FPD_SRC_BLOCKED;
      end else if (req_part == op_part) begin
        nxt_src = FPD_SRC_STATUS;
      end else begin
        nxt_src = FPD_SRC_ARRAY;
      end
    end
  end

  // per-partition busy view; global ops occupy every partition
  always_comb begin
    nxt_part_busy = 4'h0;
    for (int k = 0; k < 4; k++) begin
      nxt_part_busy[k] = op_busy_i && (op_global_i || (op_part == 2'(k)));
    end
  end

  // response strobe, one cycle after each request
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= req_valid_i;
    end
  end

  // response payload holds until the next request
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rsp_ff <= '0;
    end else if (req_valid_i) begin
      rsp_ff.loc  <= req_loc;
      rsp_ff.part <= req_part;
      rsp_ff.src  <= nxt_src;
    end
  end

  // busy flags follow the operation with one cycle of delay
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      part_busy_ff <= 4'h0;
    end else begin
      part_busy_ff <= nxt_part_busy;
    end
  end

  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_o       = rsp_ff;
  assign cfg_code_o  = cfg_code_ff;
  assign part_busy_o = part_busy_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_read_req;
    req_valid_i && req_read_i;
  endsequence

  sequence s_op_local;
    op_busy_i && !op_global_i;
  endsequence

  sequence s_cfg_load;
    cfg_wr_i && !op_busy_i;
  endsequence

  chk_cfg_reset: assert property (
    $fell(srst_i) |-> (cfg_code_o == PCFG_RST))
    else $error("partition config not at reset value");

  chk_cfg_load: assert property (
    s_cfg_load |=> (cfg_code_o == $past(cfg_code_i)))
    else $error("partition config write lost");

  chk_cfg_frozen: assert property (
    op_busy_i |=> $stable(cfg_code_o))
    else $error("partition config moved during operation");

  chk_part_span: assert property (
    fpd_part_of(cfg_code_ff, 2'h3) == 2'($countones(cfg_code_ff)))
    else $error("partition count does not match boundaries");

  chk_rsp_part: assert property (
    req_valid_i |=> rsp_valid_o &&
      (rsp_o.part == fpd_part_of($past(cfg_code_ff), rsp_o.loc.plane)))
    else $error("response partition wrong");

  chk_rsp_idle: assert property (
    !req_valid_i |=> !rsp_valid_o && $stable(rsp_o))
    else $error("response changed without request");

  chk_plane_bits: assert property (
    req_valid_i |=> (rsp_o.loc.plane == $past(req_addr_i[PL+1:PL])))
    else $error("plane index not from top address bits");

  chk_four_parts: assert property (
    (req_valid_i && cfg_code_ff == `FPD_PCFG_ALL) |=> (rsp_o.part == rsp_o.loc.plane))
    else $error("code 111 not one partition per plane");

  chk_status_read: assert property (
    (s_read_req and s_op_local and (req_part == op_part)) |=>
      (rsp_o.src == FPD_SRC_STATUS))
    else $error("busy partition read did not give status");

  chk_dual_read: assert property (
    (s_read_req and s_op_local and (req_part != op_part)) |=>
      (rsp_o.src == FPD_SRC_ARRAY))
    else $error("other partition read not served from array");

  chk_global_block: assert property (
    (s_read_req and (op_busy_i && op_global_i)) |=> (rsp_o.src == FPD_SRC_BLOCKED))
    else $error("read allowed during global operation");

  chk_busy_report: assert property (
    s_op_local |=> ($countones(part_busy_o) == 1) &&
      part_busy_o[$past(op_part)])
    else $error("busy partition report wrong");

endmodule : fpd_partition_decode

// *** src/fpd_regs.svh ***
// constants for the flash plane and partition decoder
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH

// block geometry in words
`define FPD_MAIN_BLK_WORDS  32'h8000
`define FPD_PARAM_BLK_WORDS 32'h1000
`define FPD_MAIN_SHIFT      15
`define FPD_PARAM_SHIFT     12
`define FPD_PARAM_BLKS      8
`define FPD_MAIN_BLKS_32M   63
`define FPD_MAIN_BLKS_64M   127

// word address widths and plane index position
`define FPD_AW_32M          21
`define FPD_AW_64M          22
`define FPD_PLANE_LSB_32M   19
`define FPD_PLANE_LSB_64M   20

// plane base word addresses
`define FPD_P1_BASE_32M     22'h080000
`define FPD_P2_BASE_32M     22'h100000
`define FPD_P3_BASE_32M     22'h180000
`define FPD_TOP_32M         22'h1fffff
`define FPD_P1_BASE_64M     22'h100000
`define FPD_P2_BASE_64M     22'h200000
`define FPD_P3_BASE_64M     22'h300000
`define FPD_TOP_64M         22'h3fffff

// partition configuration codes, one boundary bit per plane seam
`define FPD_PCFG_ALL        3'h7
`define FPD_PCFG_RST_TOP    3'h4
`define FPD_PCFG_RST_BOT    3'h1

`endif

// *** src/fpd_pkg.sv ***
// types and helpers for the flash plane and partition decoder
package fpd_pkg;

  typedef logic [21:0] fpd_addr_t;

  typedef struct packed {
    logic [1:0] plane;
    logic [7:0] block;
    logic       is_param;
  } fpd_loc_t;

  typedef enum logic [1:0] {
    FPD_SRC_ARRAY,
    FPD_SRC_STATUS,
    FPD_SRC_BLOCKED
  } fpd_src_t;

  typedef struct packed {
    fpd_loc_t   loc;
    logic [1:0] part;
    fpd_src_t   src;
  } fpd_rsp_t;

  // partition number of a plane: boundary bits set below it
  function automatic logic [1:0] fpd_part_of(input logic [2:0] pcfg,
                                             input logic [1:0] plane);
    logic [1:0] n;
    n = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if ((i < int'(plane)) && pcfg[i]) begin
        n = n + 2'h1;
      end
    end
    return n;
  endfunction : fpd_part_of

endpackage : fpd_pkg

// *** src/fpd_addr_decode.sv ***
// word address to plane and block decoder
`timescale 1ns/1ns
`include "fpd_regs.svh"

module fpd_addr_decode #(
  parameter bit DENSITY_64 = 1'b1,
  parameter bit TOP_PARAM  = 1'b1
) (
  input  logic               clock_i,
  input  logic               srst_i,
  input  fpd_pkg::fpd_addr_t addr_i,
  output fpd_pkg::fpd_loc_t  loc_o
);
  import fpd_pkg::*;

  localparam int AW    = DENSITY_64 ? `FPD_AW_64M : `FPD_AW_32M;
  localparam int PL    = DENSITY_64 ? `FPD_PLANE_LSB_64M : `FPD_PLANE_LSB_32M;
  localparam int SW    = AW - `FPD_MAIN_SHIFT;
  localparam int NMAIN = DENSITY_64 ? `FPD_MAIN_BLKS_64M : `FPD_MAIN_BLKS_32M;
  localparam logic [7:0] MAIN_CNT = 8'(NMAIN);
  localparam logic [7:0] LAST_BLK = 8'(NMAIN + `FPD_PARAM_BLKS - 1);
  localparam fpd_addr_t P1  = DENSITY_64 ? `FPD_P1_BASE_64M : `FPD_P1_BASE_32M;
  localparam fpd_addr_t P2  = DENSITY_64 ? `FPD_P2_BASE_64M : `FPD_P2_BASE_32M;
  localparam fpd_addr_t P3  = DENSITY_64 ? `FPD_P3_BASE_64M : `FPD_P3_BASE_32M;
  localparam fpd_addr_t TOP = DENSITY_64 ? `FPD_TOP_64M : `FPD_TOP_32M;

  // geometry must tile: eight parameter blocks fill one main slot
  if ((1 << `FPD_MAIN_SHIFT) != `FPD_MAIN_BLK_WORDS ||
      (1 << `FPD_PARAM_SHIFT) != `FPD_PARAM_BLK_WORDS ||
      `FPD_PARAM_BLKS * `FPD_PARAM_BLK_WORDS != `FPD_MAIN_BLK_WORDS ||
      NMAIN + 1 != (1 << SW) || PL != AW - 2) begin : g_geom_bad
    $error("fpd_addr_decode: inconsistent array geometry");
  end

  logic [SW-1:0] slot;
  logic [2:0]    sub;
  logic          is_param;

  // one 32K slot per main block; the boot slot splits into 4K blocks
  assign slot     = addr_i[AW-1:`FPD_MAIN_SHIFT];
  assign sub      = addr_i[`FPD_MAIN_SHIFT-1:`FPD_PARAM_SHIFT];
  assign is_param = TOP_PARAM ? (slot == {SW{1'b1}}) : (slot == '0);

  // blocks numbered from address zero upward; bit 21 ignored on 32M
  always_comb begin
    loc_o.plane    = addr_i[PL+1:PL];
    loc_o.is_param = is_param;
    if (is_param) begin
      loc_o.block = TOP_PARAM ? (MAIN_CNT + {5'h00, sub}) : {5'h00, sub};
    end else if (TOP_PARAM) begin
      loc_o.block = 8'(slot);
    end else begin
      loc_o.block = 8'(slot) + 8'(`FPD_PARAM_BLKS - 1);
    end
  end

  fpd_addr_t a_in;
  assign a_in = addr_i & TOP;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  chk_plane_range: assert property (
    loc_o.plane == ((a_in >= P3) ? 2'h3 : (a_in >= P2) ? 2'h2 :
                    (a_in >= P1) ? 2'h1 : 2'h0))
    else $error("plane does not follow address range");

  chk_param_plane: assert property (
    is_param |-> (loc_o.plane == (TOP_PARAM ? 2'h3 : 2'h0)))
    else $error("parameter block outside end plane");

  chk_block_span: assert property (
    ($stable(addr_i[AW-1:`FPD_PARAM_SHIFT]) |-> $stable(loc_o.block)) and
    ((is_param && $past(is_param) && !$stable(sub)) |-> !$stable(loc_o.block)))
    else $error("block size decode wrong");

  chk_block_count: assert property (
    loc_o.block <= LAST_BLK)
    else $error("block number beyond array");

endmodule : fpd_addr_decode

// *** test/fpd_host_model.sv ***
// host side model that issues accesses and partition config writes
`timescale 1ns/1ns

module fpd_host_model (
  input  logic               clock_i,
  output logic               cfg_wr_o,
  output logic [2:0]         cfg_code_o,
  output logic               req_valid_o,
  output logic               req_read_o,
  output fpd_pkg::fpd_addr_t req_addr_o
);
  import fpd_pkg::*;

  // quiet bus at time zero
  initial begin
    cfg_wr_o    = 1'b0;
    cfg_code_o  = 3'h0;
    req_valid_o = 1'b0;
    req_read_o  = 1'b0;
    req_addr_o  = 22'h0;
  end

  // one cycle of host activity; lines move 1 ns after the edge so the
  // decoder never sees them change in the sampling step
  task automatic put(input logic v, input logic rd, input fpd_addr_t a,
                     input logic w, input logic [2:0] c);
    @(posedge clock_i);
    #1;
    req_valid_o = v;
    req_read_o  = rd;
    req_addr_o  = a;
    cfg_wr_o    = w;
    cfg_code_o  = c;
  endtask : put
endmodule : fpd_host_model

// *** test/tb_flash_plane_partition_decode.sv ***
// self-checking bench for the plane and partition decoder, both densities
`timescale 1ns/1ns

module tb_flash_plane_partition_decode;
  import fpd_pkg::*;
  logic       clock_i, srst_i, op_busy_i, op_global_i, cfg_wr, req_valid, req_read;
  logic [2:0] cfg_code;
  fpd_addr_t  op_addr_i, req_addr;
  logic       rv [2];
  fpd_rsp_t   rsp [2], e_rsp [2];
  logic [2:0] cc [2], e_cc [2];
  logic [3:0] pb [2], e_pb [2];
  logic       e_rv;
  int         n_fail, checked, seed, r;
  fpd_addr_t  corner [12] = '{22'h0, 22'h0fffff, 22'h100000, 22'h3f7fff, 22'h3f8000,
    22'h3fffff, 22'h07ffff, 22'h080000, 22'h007fff, 22'h008000, 22'h1f7fff, 22'h1f8000};

  fpd_host_model host (.clock_i(clock_i), .cfg_wr_o(cfg_wr), .cfg_code_o(cfg_code),
    .req_valid_o(req_valid), .req_read_o(req_read), .req_addr_o(req_addr));
  // 64M top boot part
  fpd_partition_decode #(.DENSITY_64(1'b1), .TOP_PARAM(1'b1)) DUT (.clock_i(clock_i),
    .srst_i(srst_i), .cfg_wr_i(cfg_wr), .cfg_code_i(cfg_code), .req_valid_i(req_valid),
    .req_read_i(req_read), .req_addr_i(req_addr), .op_busy_i(op_busy_i),
    .op_global_i(op_global_i), .op_addr_i(op_addr_i), .rsp_valid_o(rv[0]),
    .rsp_o(rsp[0]), .cfg_code_o(cc[0]), .part_busy_o(pb[0]));
  // 32M bottom boot part on the same host lines
  fpd_partition_decode #(.DENSITY_64(1'b0), .TOP_PARAM(1'b0)) dut_small (.clock_i(clock_i),
    .srst_i(srst_i), .cfg_wr_i(cfg_wr), .cfg_code_i(cfg_code), .req_valid_i(req_valid),
    .req_read_i(req_read), .req_addr_i(req_addr), .op_busy_i(op_busy_i),
    .op_global_i(op_global_i), .op_addr_i(op_addr_i), .rsp_valid_o(rv[1]),
    .rsp_o(rsp[1]), .cfg_code_o(cc[1]), .part_busy_o(pb[1]));

  function automatic logic [1:0] pl(bit d, fpd_addr_t a);
    return d ? a[21:20] : a[20:19];
  endfunction : pl

  // partition = boundary seams passed below the plane
  function automatic logic [1:0] pn(logic [2:0] c, logic [1:0] p);
    return {1'b0, c[0] && p > 2'h0} + {1'b0, c[1] && p > 2'h1} + {1'b0, c[2] && p > 2'h2};
  endfunction : pn

  function automatic fpd_rsp_t ex(bit d, bit t, logic [2:0] c, fpd_addr_t a, logic rd);
    fpd_rsp_t    e;
    logic [22:0] x, top;
    x = d ? {1'b0, a} : {2'h0, a[20:0]};
    top = d ? 23'h400000 : 23'h200000;
    e.loc.plane = pl(d, a);
    if (t) begin
      e.loc.is_param = x >= top - 23'h8000;
      e.loc.block = e.loc.is_param ? 8'((top >> 15) - 23'h1 + ((x - top + 23'h8000) >> 12))
                                   : 8'(x >> 15);
    end else begin
      e.loc.is_param = x < 23'h8000;
      e.loc.block = e.loc.is_param ? 8'(x >> 12) : 8'((x >> 15) + 23'h7);
    end
    e.part = pn(c, e.loc.plane);
    e.src = (!rd || !op_busy_i) ? FPD_SRC_ARRAY : op_global_i ? FPD_SRC_BLOCKED :
            (pn(c, pl(d, op_addr_i)) == e.part) ? FPD_SRC_STATUS : FPD_SRC_ARRAY;
    return e;
  endfunction : ex

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // drive one cycle, check the previous one, then predict this one
  task automatic step(logic v, logic rd, fpd_addr_t a, logic w, logic [2:0] c,
                      logic b, logic g, fpd_addr_t oa);
    host.put(v, rd, a, w, c);
    op_busy_i = b;
    op_global_i = g;
    op_addr_i = oa;
    for (int i = 0; i < 2; i++) begin
      chk("rsp_valid", 32'(rv[i]), 32'(e_rv));
      chk("loc", 32'(rsp[i].loc), 32'(e_rsp[i].loc));
      chk("part", 32'(rsp[i].part), 32'(e_rsp[i].part));
      chk("src", 32'(rsp[i].src), 32'(e_rsp[i].src));
      chk("cfg_code", 32'(cc[i]), 32'(e_cc[i]));
      chk("part_busy", 32'(pb[i]), 32'(e_pb[i]));
      if (v) e_rsp[i] = ex(i == 0, i == 0, e_cc[i], a, rd);
      e_pb[i] = !b ? 4'h0 : g ? 4'hf : 4'h1 << pn(e_cc[i], pl(i == 0, oa));
      if (w && !b) e_cc[i] = c;
    end
    e_rv = v;
  endtask : step

  // reset stands for ten edges; raised at once so the very first edge
  // and a mid-run reset both start from a known level
  task automatic rst();
    srst_i = 1'b1;
    for (int k = 0; k < 10; k++) begin
      host.put(1'b0, 1'b0, 22'h0, 1'b0, 3'h0);
      srst_i = k < 9;
      op_busy_i = 1'b0;
    end
    e_rv = 1'b0;
    e_rsp = '{default: '0};
    e_pb = '{default: 4'h0};
    e_cc = '{3'h4, 3'h1};
    $display("test reset done");
  endtask : rst

  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // cut a hang well past the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    end_sim();
  end

  initial begin
    {op_busy_i, op_global_i, op_addr_i, n_fail, checked} = '0;
    seed = 29737;
    rst();
    // every partition code, read of each plane while plane 0 is busy
    for (int c = 0; c < 8; c++) begin
      step(1'b0, 1'b0, 22'h0, 1'b1, 3'(c), 1'b0, 1'b0, 22'h0);
      for (int p = 0; p < 4; p++) begin
        step(1'b1, 1'b1, {2'(p), 2'(p), 18'($random(seed))}, 1'b0, 3'h0, 1'b1, 1'b0, 22'h0);
      end
      step(1'b0, 1'b0, 22'h0, 1'b1, 3'(~c), 1'b1, 1'b0, 22'h0); // write refused while busy
    end
    $display("test partition codes done");
    // block and plane seams, back to back, plain then busy then global
    for (int k = 0; k < 36; k++) begin
      step(1'b1, k % 2 == 0, corner[k % 12], 1'b0, 3'h0, k >= 12, k >= 24, corner[k % 12]);
    end
    $display("test boundaries done");
    for (int k = 0; k < 2000; k++) begin
      r = $random(seed);
      step(r[0], r[1], 22'($random(seed)), r[4:2] == 3'h0, r[7:5], r[8], r[9] & r[10],
           22'($random(seed)));
    end
    $display("test random done");
    rst();
    step(1'b0, 1'b0, 22'h0, 1'b0, 3'h0, 1'b0, 1'b0, 22'h0);
    end_sim();
  end
endmodule : tb_flash_plane_partition_decode
